// ===== hdl/dsl_port_regs.sv
// Purpose: device status and link capabilities of one downstream port
// Assumes: config reads and writes come from the switch core, same clock;
//   mirrored control fields come from registers of the same clock
// Notes: dword access at 0x098 (status in upper half) and 0x09c
//
// Notes on behaviour
// - unused status and capability bits read zero
// - pending flag tracks outstanding nonposted request
// - aux power flag mirrors chip aux bit
// - aux flag reset equals chip bit reset
// - unsupported request completion sets its flag
// - fatal error sets fatal flag
// - nonfatal error sets nonfatal flag
// - correctable error sets correctable flag
// - logging ignores error reporting enables
// - writing one clears error flags
// - port number per downstream port index
// - link active capable mirrors general control
// - surprise down capable mirrors same field
// - clock power management bit reads one
// - link capabilities ignore writes
// - exit latencies mirror latency register fields
// - aspm support field reads 11b
// - maximum width field reads x1
// - maximum speed field reads 2.5 GT
`timescale 1ns/1ps
module dsl_port_regs #(
  parameter int port_index = 0
) (
  input wire logic ref_clk,
  input wire logic reset,
  // configuration access, dword address in bytes
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [11:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic [3:0] cfg_be,
  output logic [31:0] cfg_rdata,
  output logic cfg_rd_valid,
  // hardware events and state
  input wire logic nonposted_outstanding,
  input wire logic unsup_req_event,
  input wire logic fatal_err_event,
  input wire logic nonfatal_err_event,
  input wire logic corr_err_event,
  // mirrored fields from other registers
  input wire logic chip_aux_power_present,
  input wire logic gen_ctrl_link_active_cap,
  input wire logic [2:0] pm_lat_l1_exit,
  input wire logic [2:0] pm_lat_l0s_exit,
  // status flags out to the rest of the port
  output logic [15:0] status_out
);
  logic [3:0] err_set;
  logic [3:0] err_clear;
  logic [3:0] err_flags;
  logic [15:0] port_device_status;
  logic [31:0] port_link_capabilities;
  logic [31:0] rd_value;
  logic [15:0] status_out_reg;
  logic [15:0] status_out_next;
  logic nonposted_outstanding_flag;
  logic aux_power_seen_flag;
  logic link_active_report_capable;
  logic surprise_down_report_capable;
  logic [2:0] l1_exit_time_field;
  logic [2:0] l0s_exit_time_field;
  logic [7:0] port_number;

  // decode of an address hit on the status dword
  function automatic logic status_write(input logic [11:0] a);
    status_write = (a == dsl_pkg::dsl_status_dword);
  endfunction

  // event inputs come straight in, enables are never consulted
  always_comb begin
    err_set = '0;
    err_set[dsl_pkg::dsl_st_corr_bit] = corr_err_event;
    err_set[dsl_pkg::dsl_st_nonfatal_bit] = nonfatal_err_event;
    err_set[dsl_pkg::dsl_st_fatal_bit] = fatal_err_event;
    err_set[dsl_pkg::dsl_st_unsup_bit] = unsup_req_event;
  end

  // clear needs a one in the upper half lane, zeros leave flags alone
  always_comb begin
    err_clear = '0;
    if (cfg_wr && status_write(cfg_addr) && cfg_be[2]) begin
      err_clear = cfg_wdata[16 +: dsl_pkg::dsl_st_err_cnt];
    end
  end

  dsl_w1c_flags #(
    .width(dsl_pkg::dsl_st_err_cnt)
  ) u_flags (
    .ref_clk(ref_clk),
    .reset(reset),
    .set_pulse(err_set),
    .clear_pulse(err_clear),
    .flags(err_flags)
  );

  // live hardware bits; aux follows the chip bit so reset matches too
  always_comb begin
    nonposted_outstanding_flag = nonposted_outstanding;
    aux_power_seen_flag = chip_aux_power_present;
    port_device_status = {dsl_pkg::dsl_st_rsvd,
      nonposted_outstanding_flag, aux_power_seen_flag, err_flags};
  end

  // capabilities built from constants and mirrors only, no storage,
  // so a write has nothing to change
  always_comb begin
    port_number = dsl_pkg::dsl_port_base + 8'(port_index);
    link_active_report_capable = gen_ctrl_link_active_cap;
    surprise_down_report_capable = gen_ctrl_link_active_cap;
    l1_exit_time_field = pm_lat_l1_exit;
    l0s_exit_time_field = pm_lat_l0s_exit;
    port_link_capabilities = {
      port_number,
      dsl_pkg::dsl_cap_rsvd,
      link_active_report_capable,
      surprise_down_report_capable,
      dsl_pkg::dsl_clock_pm_yes,
      l1_exit_time_field,
      l0s_exit_time_field,
      dsl_pkg::dsl_aspm_both,
      dsl_pkg::dsl_width_x1,
      dsl_pkg::dsl_speed_2g5
    };
  end

  // read mux; unmapped dwords read zero, writes to caps dropped
  always_comb begin
    rd_value = '0;
    if (status_write(cfg_addr)) begin
      rd_value = {port_device_status, 16'h0000};
    end else if (cfg_addr == dsl_pkg::dsl_linkcap_off) begin
      rd_value = port_link_capabilities;
    end
  end

  dsl_cfg_rdreg #(
    .width(32)
  ) u_rd (
    .ref_clk(ref_clk),
    .reset(reset),
    .rd_en(cfg_rd),
    .rd_value(rd_value),
    .rd_data(cfg_rdata),
    .rd_valid(cfg_rd_valid)
  );

  // registered copy of status for downstream logic
  always_comb begin
    status_out_next = port_device_status;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      status_out_reg <= dsl_pkg::dsl_st_reset;
    end else begin
      status_out_reg <= status_out_next;
    end
  end

  assign status_out = status_out_reg;
endmodule

// ===== hdl/dsl_pkg.sv
// Purpose: constants for the downstream port status and link caps block
// Assumes: byte addresses of the config space, dword aligned access
// Notes: field positions and fixed values are kept here only
package dsl_pkg;
  // register byte offsets
  localparam logic [11:0] dsl_status_off = 12'h09a;
  localparam logic [11:0] dsl_linkcap_off = 12'h09c;
  localparam logic [11:0] dsl_status_dword = 12'h098;
  // device status field positions
  localparam int dsl_st_corr_bit = 0;
  localparam int dsl_st_nonfatal_bit = 1;
  localparam int dsl_st_fatal_bit = 2;
  localparam int dsl_st_unsup_bit = 3;
  localparam int dsl_st_aux_bit = 4;
  localparam int dsl_st_nonposted_outstanding_flag_bit = 5;
  localparam int dsl_st_err_cnt = 4;
  localparam logic [15:0] dsl_st_reset = 16'h0000;
  // link capabilities fixed fields
  localparam logic [1:0] dsl_aspm_both = 2'h3;
  localparam logic [5:0] dsl_width_x1 = 6'h01;
  localparam logic [3:0] dsl_speed_2g5 = 4'h1;
  localparam logic dsl_clock_pm_yes = 1'b1;
  localparam logic [2:0] dsl_cap_rsvd = 3'h0;
  localparam logic [9:0] dsl_st_rsvd = 10'h000;
  localparam logic [7:0] dsl_port_base = 8'h01;
endpackage

// ===== hdl/dsl_w1c_flags.sv
// Purpose: sticky error flags, set by hardware, cleared by writing one
// Assumes: set and clear pulses on ref_clk
// Notes: a set in the clearing cycle wins
`timescale 1ns/1ps
module dsl_w1c_flags #(
  parameter int width = 4
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [width-1:0] set_pulse,
  input wire logic [width-1:0] clear_pulse,
  output logic [width-1:0] flags
);
  logic [width-1:0] flags_reg;
  logic [width-1:0] flags_next;

  // per bit: set beats clear so no event is lost
  genvar i;
  generate
    for (i = 0; i < width; i++) begin : g_bit
      always_comb begin
        flags_next[i] = set_pulse[i] | (flags_reg[i] & ~clear_pulse[i]);
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;
endmodule

// ===== hdl/dsl_cfg_rdreg.sv
// Purpose: registered read data for config space reads
// Assumes: one read answered one cycle after its strobe
// Notes: data holds until the next read
`timescale 1ns/1ps
module dsl_cfg_rdreg #(
  parameter int width = 32
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic rd_en,
  input wire logic [width-1:0] rd_value,
  output logic [width-1:0] rd_data,
  output logic rd_valid
);
  logic [width-1:0] data_reg;
  logic [width-1:0] data_next;
  logic valid_reg;
  logic valid_next;

  // capture only on a read so data stands for the host
  always_comb begin
    data_next = rd_en ? rd_value : data_reg;
    valid_next = rd_en;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      data_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      data_reg <= data_next;
      valid_reg <= valid_next;
    end
  end

  assign rd_data = data_reg;
  assign rd_valid = valid_reg;
endmodule

// ===== test/dsl_port_regs_chk.sv
// Purpose: port-level checks for dsl_port_regs
// Assumes: config strobes and events sampled on ref_clk
// Notes: read data is judged one cycle after its strobe
`timescale 1ns/1ps
module dsl_port_regs_chk #(
  parameter int port_index = 0
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [11:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rd_valid,
  input wire logic nonposted_outstanding,
  input wire logic unsup_req_event,
  input wire logic fatal_err_event,
  input wire logic nonfatal_err_event,
  input wire logic corr_err_event,
  input wire logic chip_aux_power_present,
  input wire logic gen_ctrl_link_active_cap,
  input wire logic [2:0] pm_lat_l1_exit,
  input wire logic [2:0] pm_lat_l0s_exit,
  input wire logic [15:0] status_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // error events in status bit order
  wire logic [3:0] ev = {unsup_req_event, fatal_err_event,
    nonfatal_err_event, corr_err_event};
  wire logic clr = cfg_wr && cfg_addr == 12'h098 && cfg_be[2];
  wire logic caps_rd = cfg_rd && cfg_addr == 12'h09c;
  a_rd_pulse: assert property (!$past(reset) |->
    cfg_rd_valid == $past(cfg_rd)) else $error("read valid wrong");
  a_caps_low: assert property (caps_rd |=> cfg_rdata[18:0] == {1'b1,
    $past(pm_lat_l1_exit), $past(pm_lat_l0s_exit), 12'hc11})
    else $error("caps low fields wrong");
  a_caps_high: assert property (caps_rd |=> cfg_rdata[31:19] == {
    8'(port_index + 1), 3'h0, {2{$past(gen_ctrl_link_active_cap)}}})
    else $error("caps high fields wrong");
  a_status_rd: assert property (cfg_rd && cfg_addr == 12'h098 |=>
    cfg_rdata[31:22] == 10'h0 && cfg_rdata[15:0] == 16'h0 &&
    cfg_rdata[21] == $past(nonposted_outstanding) &&
    cfg_rdata[20] == $past(chip_aux_power_present))
    else $error("status read wrong");
  a_live_bits: assert property (!$past(reset) |-> status_out[5:4] ==
    {$past(nonposted_outstanding), $past(chip_aux_power_present)})
    else $error("live status bits wrong");
  a_err_logged: assert property (|ev |-> ##2
    (status_out[3:0] & $past(ev, 2)) == $past(ev, 2))
    else $error("error not logged");
  a_flags_keep: assert property (!clr |=> ##1
    (status_out[3:0] & $past(status_out[3:0])) == $past(status_out[3:0]))
    else $error("flag lost without clear");
  a_w1c_clear: assert property (clr && cfg_wdata[16] |-> ##2
    status_out[0] == $past(corr_err_event, 2)) else $error("clear wrong");
endmodule
bind dsl_port_regs dsl_port_regs_chk #(.port_index(port_index)) u_chk (.*);

// ===== test/dsl_port_regs_tb.sv
// Purpose: random bench for dsl_port_regs
// Assumes: port_index 2, one read answered per strobe
// Notes: flags modelled in an int, compared on every read of 0x098
`timescale 1ns/1ps
module dsl_port_regs_tb;
  localparam int pi = 2;
  logic ref_clk = 1'b0, reset = 1'b1, cfg_rd = 1'b0, cfg_wr = 1'b0;
  logic [11:0] cfg_addr = 12'h000;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata, want;
  logic [3:0] cfg_be = 4'h0, ev = 4'h0;
  logic nonposted_outstanding = 1'b0, chip_aux_power_present = 1'b0;
  logic gen_ctrl_link_active_cap = 1'b0, cfg_rd_valid;
  logic [2:0] pm_lat_l1_exit = 3'h0, pm_lat_l0s_exit = 3'h0;
  logic [15:0] status_out;
  int mismatches = 0, checks_done = 0, cycles = 0, m = 0;
  dsl_port_regs #(.port_index(pi)) dut (.unsup_req_event(ev[3]),
    .fatal_err_event(ev[2]), .nonfatal_err_event(ev[1]),
    .corr_err_event(ev[0]), .*);
  initial forever #2.5 ref_clk = ~ref_clk;
  // flag model: set beats a same-cycle clear
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (reset) m <= 0;
    else m <= (m & ~((cfg_wr && cfg_addr == 12'h098 && cfg_be[2]) ?
      int'(cfg_wdata[19:16]) : 0)) | int'(ev);
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // read strobe, then judge data once the model has settled
  task automatic rd(input logic [11:0] a);
    @(posedge ref_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge ref_clk);
    cfg_rd <= 1'b0;
    #1;
    want = 32'h0;
    if (a == 12'h098) want = {10'h0, nonposted_outstanding,
      chip_aux_power_present, m[3:0], 16'h0};
    if (a == 12'h09c) want = {8'(pi + 1), 3'h0, {2{gen_ctrl_link_active_cap}},
      1'b1, pm_lat_l1_exit, pm_lat_l0s_exit, 12'hc11};
    check({cfg_rd_valid, cfg_rdata}, {1'b1, want});
    if (a == 12'h098) check({17'h0, status_out}, {17'h0, want[31:16]});
  endtask
  task automatic finish_test();
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h3fc4163f));
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    rd(12'h098);
    // random events racing random writes, then both reads
    for (int i = 0; i < 400; i++) begin
      @(posedge ref_clk);
      {nonposted_outstanding, chip_aux_power_present, gen_ctrl_link_active_cap,
        pm_lat_l1_exit, pm_lat_l0s_exit} <= 9'($urandom);
      ev <= 4'($urandom) & 4'($urandom);
      cfg_wr <= 1'($urandom);
      cfg_addr <= $urandom_range(1) ? 12'h098 : 12'h09c;
      cfg_be <= 4'($urandom);
      cfg_wdata <= $urandom;
      @(posedge ref_clk);
      cfg_wr <= 1'b0;
      ev <= 4'h0;
      rd(12'h098);
      rd(12'h09c);
    end
    rd(12'h0a0);
    finish_test();
  end
endmodule
